// ==== hdl/status_led_defs.vh ====
// Constants shared by the status indicator logic
`ifndef STATUS_LED_DEFS_VH
`define STATUS_LED_DEFS_VH

// Timebase: clock rate and one millisecond step
`define CLK_HZ 20000000
`define TICK_TIME_MS 1
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_TIME_MS)

// Structure
`define NUM_AXES 4
`define NUM_LINKS 2
`define NUM_EXT_INPUTS 8
`define ADDR_W 8

// Register byte addresses
`define REG_TIMING_BLINK 8'h00
`define REG_TIMING_AUX 8'h04
`define REG_EXT_ASSIGN 8'h08
`define REG_STATUS 8'h0c

// Reset values of the timing registers, in milliseconds, and of the extension assignment register
`define RST_ON_MS 16'h00c8
`define RST_OFF_MS 16'h00c8
`define RST_FLICKER_MS 16'h0032
`define RST_LONG_MS 16'h03e8
`define RST_EXT_ASSIGN 16'h0000

// Extension assignment field: 3-bit input select and enable, per axis
`define EXT_FIELD_W 4
`define EXT_SEL_W 3
`define EXT_EN_BIT 3

// Status register field positions
`define ST_RUN 0
`define ST_ERR 1
`define ST_COMM_ALARM 2
`define ST_LINK_LSB 3
`define ST_POWER_LSB 8
`define ST_ALARM_LSB 12
`define ST_REGEN 16
`define ST_OVERHEAT 17
`define ST_NODE_LSB 24

// Fieldbus state machine phase codes
`define FB_INIT 2'h0
`define FB_PREOP 2'h1
`define FB_SAFEOP 2'h2
`define FB_OP 2'h3

// Fieldbus error class codes
`define FERR_NONE 2'h0
`define FERR_SETTING 2'h1
`define FERR_DATA 2'h2
`define FERR_WATCHDOG 2'h3

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== hdl/led_pattern_gen.v ====
// Shared millisecond timebase and blink pattern generator
`default_nettype none
`include "status_led_defs.vh"

module led_pattern_gen #(
   parameter TICK_CYCLES = `TICK_CYCLES
) (
   input wire aclk,
   input wire aresetn,
   input wire [15:0] on_ms,
   input wire [15:0] off_ms,
   input wire [15:0] flicker_ms,
   input wire [15:0] long_ms,
   output reg blink,
   output reg single_flash,
   output reg double_flash,
   output reg flicker,
   output reg [2:0] sim_phase
);
   localparam F_ON1 = 4'b0001;
   localparam F_GAP = 4'b0010;
   localparam F_ON2 = 4'b0100;
   localparam F_REST = 4'b1000;

   reg [23:0] tick_cnt;
   reg tick;
   reg [16:0] bcnt;
   reg [15:0] fcnt;
   reg [15:0] kcnt;
   reg [3:0] fstate;
   reg [15:0] fdur;
   wire [16:0] bperiod = {1'b0, on_ms} + {1'b0, off_ms};
   wire [16:0] fnext = {1'b0, fcnt} + 17'h00001;
   wire [16:0] knext = {1'b0, kcnt} + 17'h00001;
   wire [16:0] bnext = bcnt + 17'h00001;

   // Phase length of the flash sequence
   always @* begin
      case (fstate)
         F_ON1: fdur = on_ms;
         F_GAP: fdur = off_ms;
         F_ON2: fdur = on_ms;
         F_REST: fdur = long_ms;
         default: fdur = on_ms;
      endcase
   end

   // Millisecond tick, one cycle wide
   always @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt <= 24'h000000;
         tick <= 1'b0;
      end else if (tick_cnt >= TICK_CYCLES[23:0] - 24'h000001) begin
         tick_cnt <= 24'h000000;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 24'h000001;
         tick <= 1'b0;
      end
   end

   // Blink frame, flicker toggle, flash sequence and simulation phase
   always @(posedge aclk) begin
      if (!aresetn) begin
         bcnt <= 17'h00000;
         fcnt <= 16'h0000;
         kcnt <= 16'h0000;
         fstate <= F_ON1;
         blink <= 1'b0;
         single_flash <= 1'b0;
         double_flash <= 1'b0;
         flicker <= 1'b0;
         sim_phase <= 3'b001;
      end else begin
         if (tick) begin
            // Zero periods act as one step so the frame never stalls
            if (bnext >= bperiod) begin
               bcnt <= 17'h00000;
               sim_phase <= {sim_phase[1:0], sim_phase[2]};
            end else begin
               bcnt <= bnext;
            end
            if (knext >= {1'b0, flicker_ms}) begin
               kcnt <= 16'h0000;
               flicker <= ~flicker;
            end else begin
               kcnt <= knext[15:0];
            end
            if (fnext >= {1'b0, fdur}) begin
               fcnt <= 16'h0000;
               case (fstate)
                  F_ON1: fstate <= F_GAP;
                  F_GAP: fstate <= F_ON2;
                  F_ON2: fstate <= F_REST;
                  F_REST: fstate <= F_ON1;
                  default: fstate <= F_ON1;
               endcase
            end else begin
               fcnt <= fnext[15:0];
            end
         end
         blink <= (bcnt < {1'b0, on_ms});
         single_flash <= (fstate == F_ON1);
         double_flash <= (fstate == F_ON1) || (fstate == F_ON2);
      end
   end
endmodule
`default_nettype wire

// ==== hdl/status_led_indicator.v ====
// Front-panel status indicator logic with an AXI4-Lite register slave
//
// Contract
// - Run light: dark init, blink pre-op, single flash safe-op, lit operational.
// - Error light: dark none, blink setting, single flash data, double flash watchdog.
// - Comm-axis alarm light: dark none, blink on alarm, lit on processor error.
// - Link light: dark without link, lit with link, flickers during traffic.
// - Axis normal: power lit, alarm dark; alarm present: power lit, alarm blinks.
// - Information or remote operation: power and alarm double-flash together.
// - Simulation: cycle power lit, then alarm lit, then both lit.
// - Node address is tens switch times ten plus units switch; zero as shipped.
// - Power light only while the axis control supply is healthy.
// - Extension push switch asserts whichever input is assigned to it.
// - Regeneration light follows regeneration; overheat light follows resistor overheat.
`default_nettype none
`include "status_led_defs.vh"

module status_led_indicator #(
   parameter TICK_CYCLES = `TICK_CYCLES
) (
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite slave
   input wire [`ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Internal states of the controller axis
   input wire [1:0] fb_state,
   input wire [1:0] fb_error,
   input wire comm_alarm,
   input wire cpu_error,
   input wire [`NUM_LINKS-1:0] link_up,
   input wire [`NUM_LINKS-1:0] link_activity,
   // Internal states of the driver axes
   input wire [`NUM_AXES-1:0] ctrl_supply_ok,
   input wire [`NUM_AXES-1:0] axis_alarm,
   input wire [`NUM_AXES-1:0] axis_info,
   input wire [`NUM_AXES-1:0] remote_op,
   input wire [`NUM_AXES-1:0] simulating,
   input wire regen_active,
   input wire resistor_overheat,
   // Operator switches
   input wire [3:0] node_addr_tens_switch,
   input wire [3:0] node_addr_units_switch,
   input wire [`NUM_AXES-1:0] extension_push_switch,
   // Indicators and derived outputs
   output reg run_led,
   output reg err_led,
   output reg comm_alarm_led,
   output reg [`NUM_LINKS-1:0] link_led,
   output reg [`NUM_AXES-1:0] power_led,
   output reg [`NUM_AXES-1:0] alarm_led,
   output reg regeneration_indicator,
   output reg resistor_overheat_indicator,
   output reg [6:0] node_addr,
   output reg [`NUM_AXES*`NUM_EXT_INPUTS-1:0] ext_input_assert
);
   reg [15:0] on_ms;
   reg [15:0] off_ms;
   reg [15:0] flicker_ms;
   reg [15:0] long_ms;
   reg [15:0] ext_assign;
   reg [`ADDR_W-1:0] wr_addr;
   reg [31:0] wr_data;
   reg [3:0] wr_strb;
   reg [31:0] next_rdata;
   reg next_rerr;
   reg wr_hit;
   reg [31:0] status_word;
   wire blink;
   wire single_flash;
   wire double_flash;
   wire flicker;
   wire [2:0] sim_phase;
   wire [31:0] ext_merged;

   // Byte-lane merge of a write into a 32-bit register image
   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge[i*8 +: 8] = data[i*8 +: 8];
            end
         end
      end
   endfunction

   // Full-word merge; only the low half is kept for the assignment register
   assign ext_merged = merge({16'h0000, ext_assign}, wr_data, wr_strb);

   led_pattern_gen #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_patterns (
      .aclk(aclk),
      .aresetn(aresetn),
      .on_ms(on_ms),
      .off_ms(off_ms),
      .flicker_ms(flicker_ms),
      .long_ms(long_ms),
      .blink(blink),
      .single_flash(single_flash),
      .double_flash(double_flash),
      .flicker(flicker),
      .sim_phase(sim_phase)
   );

   // Status image built from the indicators as they are shown
   always @* begin
      status_word = 32'h00000000;
      status_word[`ST_RUN] = run_led;
      status_word[`ST_ERR] = err_led;
      status_word[`ST_COMM_ALARM] = comm_alarm_led;
      status_word[`ST_LINK_LSB +: `NUM_LINKS] = link_led;
      status_word[`ST_POWER_LSB +: `NUM_AXES] = power_led;
      status_word[`ST_ALARM_LSB +: `NUM_AXES] = alarm_led;
      status_word[`ST_REGEN] = regeneration_indicator;
      status_word[`ST_OVERHEAT] = resistor_overheat_indicator;
      status_word[`ST_NODE_LSB +: 7] = node_addr;
   end

   // Read decode; unmapped addresses answer with a slave error
   always @* begin
      next_rdata = 32'h00000000;
      next_rerr = 1'b0;
      case (s_axi_araddr)
         `REG_TIMING_BLINK: next_rdata = {off_ms, on_ms};
         `REG_TIMING_AUX: next_rdata = {long_ms, flicker_ms};
         `REG_EXT_ASSIGN: next_rdata = {16'h0000, ext_assign};
         `REG_STATUS: next_rdata = status_word;
         default: next_rerr = 1'b1;
      endcase
   end

   // Write decode of the held address; the status word is read-only
   always @* begin
      case (wr_addr)
         `REG_TIMING_BLINK: wr_hit = 1'b1;
         `REG_TIMING_AUX: wr_hit = 1'b1;
         `REG_EXT_ASSIGN: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // Write channel: address and data taken in either order, then one response
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         wr_addr <= {`ADDR_W{1'b0}};
         wr_data <= 32'h00000000;
         wr_strb <= 4'h0;
         on_ms <= `RST_ON_MS;
         off_ms <= `RST_OFF_MS;
         flicker_ms <= `RST_FLICKER_MS;
         long_ms <= `RST_LONG_MS;
         ext_assign <= `RST_EXT_ASSIGN;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            wr_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         // Both halves held: commit and respond in the same edge
         if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            case (wr_addr)
               `REG_TIMING_BLINK: {off_ms, on_ms} <=
                  merge({off_ms, on_ms}, wr_data, wr_strb);
               `REG_TIMING_AUX: {long_ms, flicker_ms} <=
                  merge({long_ms, flicker_ms}, wr_data, wr_strb);
               `REG_EXT_ASSIGN: ext_assign <= ext_merged[15:0];
               default: ext_assign <= ext_assign;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Read channel: answer on the same edge that takes the address
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rerr ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Controller axis indicators
   always @(posedge aclk) begin
      if (!aresetn) begin
         run_led <= 1'b0;
         err_led <= 1'b0;
         comm_alarm_led <= 1'b0;
         regeneration_indicator <= 1'b0;
         resistor_overheat_indicator <= 1'b0;
         node_addr <= 7'h00;
      end else begin
         case (fb_state)
            `FB_INIT: run_led <= 1'b0;
            `FB_PREOP: run_led <= blink;
            `FB_SAFEOP: run_led <= single_flash;
            `FB_OP: run_led <= 1'b1;
            default: run_led <= 1'b0;
         endcase
         case (fb_error)
            `FERR_NONE: err_led <= 1'b0;
            `FERR_SETTING: err_led <= blink;
            `FERR_DATA: err_led <= single_flash;
            `FERR_WATCHDOG: err_led <= double_flash;
            default: err_led <= 1'b0;
         endcase
         // A processor error outranks an ordinary alarm
         if (cpu_error) begin
            comm_alarm_led <= 1'b1;
         end else if (comm_alarm) begin
            comm_alarm_led <= blink;
         end else begin
            comm_alarm_led <= 1'b0;
         end
         regeneration_indicator <= regen_active;
         resistor_overheat_indicator <= resistor_overheat;
         // Switches are decimal; settings above nine are not range-checked
         node_addr <= {3'h0, node_addr_tens_switch} * 7'h0a
            + {3'h0, node_addr_units_switch};
      end
   end

   genvar g;
   genvar b;

   // Link and traffic indicator per port
   generate
      for (g = 0; g < `NUM_LINKS; g = g + 1) begin : link_gen
         always @(posedge aclk) begin
            if (!aresetn) begin
               link_led[g] <= 1'b0;
            end else if (!link_up[g]) begin
               link_led[g] <= 1'b0;
            end else if (link_activity[g]) begin
               link_led[g] <= flicker;
            end else begin
               link_led[g] <= 1'b1;
            end
         end
      end
   endgenerate

   // Driver axis indicators and extension switch, one slice per axis
   generate
      for (g = 0; g < `NUM_AXES; g = g + 1) begin : axis_gen
         wire [`EXT_FIELD_W-1:0] field = ext_assign[g*`EXT_FIELD_W +: `EXT_FIELD_W];
         wire [`EXT_SEL_W-1:0] sel = field[`EXT_SEL_W-1:0];
         wire en = field[`EXT_EN_BIT];
         // Supply loss darkens both; simulation outranks information
         always @(posedge aclk) begin
            if (!aresetn) begin
               power_led[g] <= 1'b0;
               alarm_led[g] <= 1'b0;
            end else if (!ctrl_supply_ok[g]) begin
               power_led[g] <= 1'b0;
               alarm_led[g] <= 1'b0;
            end else if (simulating[g]) begin
               power_led[g] <= sim_phase[0] | sim_phase[2];
               alarm_led[g] <= sim_phase[1] | sim_phase[2];
            end else if (axis_info[g] || remote_op[g]) begin
               power_led[g] <= double_flash;
               alarm_led[g] <= double_flash;
            end else if (axis_alarm[g]) begin
               power_led[g] <= 1'b1;
               alarm_led[g] <= blink;
            end else begin
               power_led[g] <= 1'b1;
               alarm_led[g] <= 1'b0;
            end
         end
         // Pressing acts like the assigned input; held for as long as pressed
         for (b = 0; b < `NUM_EXT_INPUTS; b = b + 1) begin : bit_gen
            localparam [`EXT_SEL_W-1:0] SEL_CODE = b;
            always @(posedge aclk) begin
               if (!aresetn) begin
                  ext_input_assert[g*`NUM_EXT_INPUTS + b] <= 1'b0;
               end else begin
                  ext_input_assert[g*`NUM_EXT_INPUTS + b] <=
                     extension_push_switch[g] & en & (sel == SEL_CODE);
               end
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ==== verification/status_led_monitor.sv ====
// Concurrent checks on the status indicator outputs
`default_nettype none
`include "status_led_defs.vh"
module status_led_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] fb_state,
   input wire logic [1:0] fb_error,
   input wire logic cpu_error,
   input wire logic [`NUM_LINKS-1:0] link_up,
   input wire logic [`NUM_LINKS-1:0] link_activity,
   input wire logic [`NUM_AXES-1:0] ctrl_supply_ok,
   input wire logic [`NUM_AXES-1:0] axis_alarm,
   input wire logic [`NUM_AXES-1:0] axis_info,
   input wire logic [`NUM_AXES-1:0] remote_op,
   input wire logic [`NUM_AXES-1:0] simulating,
   input wire logic regen_active,
   input wire logic resistor_overheat,
   input wire logic [3:0] node_addr_tens_switch,
   input wire logic [3:0] node_addr_units_switch,
   input wire logic run_led,
   input wire logic err_led,
   input wire logic comm_alarm_led,
   input wire logic [`NUM_LINKS-1:0] link_led,
   input wire logic [`NUM_AXES-1:0] power_led,
   input wire logic [`NUM_AXES-1:0] alarm_led,
   input wire logic regeneration_indicator,
   input wire logic resistor_overheat_indicator,
   input wire logic [6:0] node_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   // Address the switches ask for; a wrong weight shows at once
   wire logic [6:0] exp_addr;
   wire logic axis0_quiet;
   assign exp_addr = 7'(node_addr_tens_switch) * 7'h0a + 7'(node_addr_units_switch);
   assign axis0_quiet = ctrl_supply_ok[0] && !simulating[0] && !axis_info[0] && !remote_op[0];

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_run_dark: assert property (fb_state == `FB_INIT |=> !run_led)
      else $error("run light lit in init state");
   a_run_lit: assert property (fb_state == `FB_OP |=> run_led)
      else $error("run light dark in operational state");
   a_err_dark: assert property (fb_error == `FERR_NONE |=> !err_led)
      else $error("error light lit without error");
   a_cpu_lit: assert property (cpu_error [*2] |=> comm_alarm_led)
      else $error("alarm light not steady on processor error");
   a_link_dark: assert property (!link_up[0] |=> !link_led[0])
      else $error("link light lit without link");
   a_link_lit: assert property (link_up[0] && !link_activity[0] |=> link_led[0])
      else $error("link light dark on idle link");
   a_axis_normal: assert property (axis0_quiet && !axis_alarm[0] |=> power_led[0] && !alarm_led[0])
      else $error("axis lights wrong in normal operation");
   a_power_off: assert property (!ctrl_supply_ok[0] |=> !power_led[0])
      else $error("power light lit without control supply");
   a_regen_follow: assert property (1'b1 |=> regeneration_indicator == $past(regen_active))
      else $error("regeneration light does not follow state");
   a_heat_rise: assert property ($rose(resistor_overheat) |=> resistor_overheat_indicator)
      else $error("overheat light missed overheat");
   a_node_addr: assert property (1'b1 |=> node_addr == $past(exp_addr))
      else $error("node address differs from switches");

   // Main scenarios reached
   c_run_op: cover property (fb_state == `FB_OP ##1 run_led);
   c_cpu: cover property (cpu_error ##1 comm_alarm_led);
   c_sim_both: cover property (simulating[0] && power_led[0] && alarm_led[0]);
endmodule
bind status_led_indicator status_led_monitor mon (.*);
`default_nettype wire

// ==== verification/led_observer.sv ====
// Operator model: counts flashes and lit time of each watched light
`default_nettype none
module led_observer #(
   parameter int N = 6
) (
   input wire logic aclk,
   input wire logic clr,
   input wire logic [N-1:0] led,
   output var int rises [N],
   output var int lit [N]
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [N-1:0] prev;
   // An eye sees only edges and time lit, never the pattern logic
   always @(posedge aclk) begin
      prev <= led;
      for (int i = 0; i < N; i++) begin
         if (clr) begin
            rises[i] <= 0;
            lit[i] <= 0;
         end else begin
            if (led[i] && !prev[i]) rises[i] <= rises[i] + 1;
            if (led[i]) lit[i] <= lit[i] + 1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// Register and indicator tests for the status indicator block
`default_nettype none
`include "status_led_defs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, clr;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, fb_state, fb_error;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic comm_alarm, cpu_error, regen_active, resistor_overheat;
   logic [1:0] link_up, link_activity, link_led;
   logic [3:0] ctrl_supply_ok, axis_alarm, axis_info, remote_op, simulating;
   logic [3:0] node_addr_tens_switch, node_addr_units_switch, extension_push_switch;
   logic run_led, err_led, comm_alarm_led, regeneration_indicator, resistor_overheat_indicator;
   logic [3:0] power_led, alarm_led;
   logic [6:0] node_addr;
   logic [31:0] ext_input_assert, rd;
   logic [1:0] rs;
   int n_fail, samples_checked, pat_mix;
   int rises [6], lit [6], combo [4];
   // Counts expected in 160 cycles, lit cycles for dark and lit, rising edges otherwise: dark, blink, single, lit, double, flicker
   int lo [6] = '{0, 9, 3, 160, 7, 19};
   int hi [6] = '{0, 11, 5, 160, 9, 21};

   status_led_indicator #(.TICK_CYCLES(4)) dut (.*);
   led_observer #(.N(6)) eye (.aclk(aclk), .clr(clr), .rises(rises), .lit(lit),
      .led({alarm_led[0], power_led[0], link_led[0], comm_alarm_led, err_led, run_led}));

   // Free-running clock
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   task end_sim;
      if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task chk_rng(input string nm, input int l, input int h, input int g);
      samples_checked++;
      if (g < l || g > h) begin
         n_fail++;
         $display("[ERR] %s expected %0d..%0d seen %0d", nm, l, h, g);
      end
   endtask

   // A wait that runs out ends the run as a failure
   task tmo(input int n);
      if (n > 200) begin
         n_fail++;
         $display("[ERR] handshake expected response seen none");
         end_sim();
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
         tmo(n);
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
         tmo(n);
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      axr(a, rd, rs);
      chk(nm, e, rd);
      chk("read response", {30'h0, er}, {30'h0, rs});
   endtask

   task wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      axw(a, d, rs);
      chk("write response", {30'h0, er}, {30'h0, rs});
   endtask

   // Let the pattern settle, then watch for 160 cycles; light -1 only gathers counts
   task pat(input int i, input int k);
      repeat (60) @(posedge aclk);
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      pat_mix = 0;
      combo = '{0, 0, 0, 0};
      repeat (160) begin
         @(posedge aclk);
         if (power_led[0] !== alarm_led[0]) pat_mix++;
         combo[{alarm_led[0], power_led[0]}]++;
      end
      #1;
      if (i >= 0) chk_rng($sformatf("light%0d", i), lo[k], hi[k], (k == 0 || k == 3) ? lit[i] : rises[i]);
      @(posedge aclk);
   endtask

   // Main sequence
   initial begin
      {aresetn, clr, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, fb_state, fb_error} = '0;
      {comm_alarm, cpu_error, regen_active, resistor_overheat, link_up, link_activity} = '0;
      {ctrl_supply_ok, axis_alarm, axis_info, remote_op, simulating} = '0;
      {node_addr_tens_switch, node_addr_units_switch, extension_push_switch} = '0;
      n_fail = 0;
      samples_checked = 0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      chk("node_addr", 32'h0, {25'h0, node_addr});
      rd_chk("timing_blink", `REG_TIMING_BLINK, 32'h00c8_00c8, `RESP_OKAY);
      rd_chk("timing_aux", `REG_TIMING_AUX, 32'h03e8_0032, `RESP_OKAY);
      rd_chk("ext_assign", `REG_EXT_ASSIGN, 32'h0, `RESP_OKAY);
      rd_chk("unmapped", 8'h10, 32'h0, `RESP_SLVERR);
      wr_chk(`REG_STATUS, 32'hffff_ffff, `RESP_SLVERR);
      wr_chk(`REG_TIMING_BLINK, 32'h0002_0002, `RESP_OKAY);
      wr_chk(`REG_TIMING_AUX, 32'h0004_0001, `RESP_OKAY);
      rd_chk("timing_aux", `REG_TIMING_AUX, 32'h0004_0001, `RESP_OKAY);
      for (int s = 0; s < 4; s++) begin
         fb_state <= 2'(s);
         pat(0, s);
         fb_error <= 2'(s);
         pat(1, (s == 3) ? 4 : s);
      end
      pat(2, 0);
      comm_alarm <= 1'b1;
      pat(2, 1);
      cpu_error <= 1'b1;
      pat(2, 3);
      pat(3, 0);
      link_up <= 2'h3;
      pat(3, 3);
      chk("link1", 32'h1, {31'h0, link_led[1]});
      link_activity <= 2'h3;
      pat(3, 5);
      ctrl_supply_ok <= 4'hf;
      pat(4, 3);
      pat(5, 0);
      axis_alarm <= 4'h1;
      pat(4, 3);
      pat(5, 1);
      chk("other_axes", 32'h38, {26'h0, power_led[3:1], alarm_led[3:1]});
      axis_info <= 4'h1;
      pat(4, 4);
      chk("info_mismatch", 32'h0, pat_mix);
      axis_info <= 4'h0;
      remote_op <= 4'h1;
      pat(5, 4);
      chk("remote_mismatch", 32'h0, pat_mix);
      simulating <= 4'h1;
      pat(-1, 0);
      chk("sim_dark", 32'h0, combo[0]);
      for (int c = 1; c < 4; c++) chk_rng("sim_phase", 1, 160, combo[c]);
      ctrl_supply_ok <= 4'h0;
      pat(4, 0);
      regen_active <= 1'b1;
      repeat (2) @(posedge aclk);
      chk("regen", 32'h1, {31'h0, regeneration_indicator});
      chk("overheat", 32'h0, {31'h0, resistor_overheat_indicator});
      regen_active <= 1'b0;
      resistor_overheat <= 1'b1;
      node_addr_tens_switch <= 4'h4;
      node_addr_units_switch <= 4'h2;
      repeat (2) @(posedge aclk);
      chk("regen", 32'h0, {31'h0, regeneration_indicator});
      chk("overheat", 32'h1, {31'h0, resistor_overheat_indicator});
      chk("node_addr", 32'h2a, {25'h0, node_addr});
      node_addr_tens_switch <= 4'h9;
      node_addr_units_switch <= 4'h9;
      repeat (2) @(posedge aclk);
      axr(`REG_STATUS, rd, rs);
      chk("status_node", 32'h63, {25'h0, rd[30:24]});
      wr_chk(`REG_EXT_ASSIGN, 32'h0000_00d0, `RESP_OKAY);
      rd_chk("ext_assign", `REG_EXT_ASSIGN, 32'h0000_00d0, `RESP_OKAY);
      extension_push_switch <= 4'h2;
      repeat (2) @(posedge aclk);
      chk("ext_input", 32'h0000_2000, ext_input_assert);
      extension_push_switch <= 4'h0;
      repeat (2) @(posedge aclk);
      chk("ext_input", 32'h0, ext_input_assert);
      wr_chk(`REG_EXT_ASSIGN, 32'h0000_0050, `RESP_OKAY);
      extension_push_switch <= 4'h2;
      repeat (2) @(posedge aclk);
      chk("ext_input", 32'h0, ext_input_assert);
      end_sim();
   end
endmodule
`default_nettype wire
